// [include/osw_pkg.sv]
// Constants, types and register map of the oscillator switch control block
//
// Summary of operation
// - Clock-fail flag sets on monitor failure, stays set until software clears it.
// - Secondary oscillator enable bit: write 1 enables, write 0 disables the oscillator.
// - Switch request starts switch to selected source; hardware clears it when done.
// - Control register writes take effect only after the unlock key sequence.
// - Control register returns to reset values only on power-on reset.
package osw_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OSW_CTRL_OFS = 8'h00;
  localparam logic [7:0] OSW_KEY_OFS  = 8'h04;

  // Control register field positions
  localparam int OSW_SWREQ_BIT  = 0;
  localparam int OSW_LPOSC_BIT  = 1;
  localparam int OSW_CFAIL_BIT  = 3;
  localparam int OSW_NOSC_LSB   = 8;
  localparam int OSW_CUR_LSB    = 12;
  localparam int OSW_SEL_W      = 3;

  // Power-on values of the control register fields
  localparam logic [2:0] OSW_NOSC_RST  = 3'h0;
  localparam logic       OSW_LPOSC_RST = 1'b0;
  localparam logic       OSW_SWREQ_RST = 1'b0;
  localparam logic       OSW_CFAIL_RST = 1'b0;

  // Unlock keys, written in this order to the key register
  localparam logic [15:0] OSW_KEY1 = 16'h5a3c;
  localparam logic [15:0] OSW_KEY2 = 16'hc3a5;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int OSW_HTRANS_ACT = 1;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    OSW_LK_IDLE = 2'b00,
    OSW_LK_HALF = 2'b01,
    OSW_LK_OPEN = 2'b10
  } osw_lock_t;

  // Address phase captured for the data phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ofs;
  } osw_xfer_t;

endpackage

// [src/osw_unlock.sv]
// Unlock key sequencer that gates writes to the oscillator control register
`timescale 1ns/10ps
module osw_unlock import osw_pkg::*; (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Write events from the bus slave
  input  wire logic        wr_any,
  input  wire logic        wr_key,
  input  wire logic [15:0] key_data,
  // Sequencer state
  output osw_lock_t        lock_state
);

  osw_lock_t state_q;
  osw_lock_t state_d;

  // Any write that breaks the key pair, or consumes the opening, relocks
  always_comb begin
    state_d = state_q;
    if (wr_any) begin
      case (state_q)
        OSW_LK_IDLE: begin
          state_d = (wr_key && key_data == OSW_KEY1) ? OSW_LK_HALF : OSW_LK_IDLE;
        end
        OSW_LK_HALF: begin
          state_d = (wr_key && key_data == OSW_KEY2) ? OSW_LK_OPEN : OSW_LK_IDLE;
        end
        OSW_LK_OPEN: begin
          state_d = (wr_key && key_data == OSW_KEY1) ? OSW_LK_HALF : OSW_LK_IDLE;
        end
        default: begin
          state_d = OSW_LK_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= OSW_LK_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign lock_state = state_q;

endmodule // osw_unlock

// [src/osw_osc_ctrl.sv]
// Oscillator control register with unlock, switch request and clock-fail flag
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module osw_osc_ctrl import osw_pkg::*; (
  // Clock and resets
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Clock monitor and source multiplexer
  input  wire logic        clk_fail_detect,
  input  wire logic        switch_done,
  input  wire logic [2:0]  cur_osc_sel,
  // Oscillator controls
  output logic [2:0]       new_osc_select,
  output logic             osc_switch_request,
  output logic             secondary_osc_enable,
  output logic             clock_fail_flag
);

  // Bus state
  osw_xfer_t   xfer_q;
  osw_xfer_t   xfer_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ready_q;
  logic        resp_q;

  // Control register state, cleared by power-on reset only
  logic [2:0]  nosc_q;
  logic [2:0]  nosc_d;
  logic        lposc_q;
  logic        lposc_d;
  logic        swreq_q;
  logic        swreq_d;
  logic        cfail_q;
  logic        cfail_d;

  // Decoded data-phase writes
  logic        ctrl_wr;
  logic        key_wr;
  logic        ctrl_ok;
  osw_lock_t   lock_state;

  // Address phase capture; only whole-word accesses are expected
  always_comb begin
    xfer_d     = '0;
    xfer_d.ofs = haddr[7:0];
    if (hsel && hready && htrans[OSW_HTRANS_ACT]) begin
      xfer_d.wr = hwrite;
      xfer_d.rd = !hwrite;
    end
  end

  // Data phase decode
  always_comb begin
    ctrl_wr = 1'b0;
    key_wr  = 1'b0;
    if (xfer_q.wr && xfer_q.ofs == OSW_CTRL_OFS) begin
      ctrl_wr = 1'b1;
    end else if (xfer_q.wr && xfer_q.ofs == OSW_KEY_OFS) begin
      key_wr = 1'b1;
    end
  end

  // Control write lands only straight after a completed key pair
  assign ctrl_ok = ctrl_wr && (lock_state == OSW_LK_OPEN);

  // Key sequencer
  osw_unlock u_unlock (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .wr_any     (xfer_q.wr),
    .wr_key     (key_wr),
    .key_data   (hwdata[15:0]),
    .lock_state (lock_state)
  );

  // Next values of the control fields
  always_comb begin
    nosc_d  = nosc_q;
    lposc_d = lposc_q;
    swreq_d = swreq_q;
    cfail_d = cfail_q;
    // Selection is frozen while a switch is in flight
    if (ctrl_ok && !swreq_q) begin
      nosc_d = hwdata[OSW_NOSC_LSB +: OSW_SEL_W];
    end
    if (ctrl_ok) begin
      lposc_d = hwdata[OSW_LPOSC_BIT];
    end
    // Software can only start a switch; the multiplexer ends it
    if (swreq_q && switch_done) begin
      swreq_d = 1'b0;
    end else if (ctrl_ok && hwdata[OSW_SWREQ_BIT]) begin
      swreq_d = 1'b1;
    end
    // Failure set wins over a clearing write in the same cycle
    if (clk_fail_detect) begin
      cfail_d = 1'b1;
    end else if (ctrl_ok && !hwdata[OSW_CFAIL_BIT]) begin
      cfail_d = 1'b0;
    end
  end

  // Control registers on the power-on reset alone
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      nosc_q  <= OSW_NOSC_RST;
      lposc_q <= OSW_LPOSC_RST;
      swreq_q <= OSW_SWREQ_RST;
      cfail_q <= OSW_CFAIL_RST;
    end else begin
      nosc_q  <= nosc_d;
      lposc_q <= lposc_d;
      swreq_q <= swreq_d;
      cfail_q <= cfail_d;
    end
  end

  // Control register read data built from next values so a read right after a write sees it; key reads show lock_state, or 0 behind a write
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (xfer_d.rd && xfer_d.ofs == OSW_CTRL_OFS) begin
      rdata_d[OSW_SWREQ_BIT]                 = swreq_d;
      rdata_d[OSW_LPOSC_BIT]                 = lposc_d;
      rdata_d[OSW_CFAIL_BIT]                 = cfail_d;
      rdata_d[OSW_NOSC_LSB +: OSW_SEL_W]     = nosc_d;
      rdata_d[OSW_CUR_LSB +: OSW_SEL_W]      = cur_osc_sel;
    end else if (xfer_d.rd && xfer_d.ofs == OSW_KEY_OFS) begin
      rdata_d[1:0] = (xfer_q.wr) ? 2'h0 : lock_state;
    end
  end

  // Bus registers; zero wait states and always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_q  <= '0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      resp_q  <= 1'b0;
    end else begin
      xfer_q  <= xfer_d;
      rdata_q <= rdata_d;
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign hreadyout            = ready_q;
  assign hrdata               = rdata_q;
  assign hresp                = resp_q;
  assign new_osc_select       = nosc_q;
  assign osc_switch_request   = swreq_q;
  assign secondary_osc_enable = lposc_q;
  assign clock_fail_flag      = cfail_q;

  // Software keeps PLL-to-PLL switches routed via the fast RC source; not checked here

endmodule // osw_osc_ctrl

// [tb/osw_osc_ctrl_props.sv]
// Port checks for the oscillator switch control block
`timescale 1ns/10ps
module osw_osc_ctrl_props (
  // Clock and resets
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       por_n,
  // Bus request
  input wire logic       hsel,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic [1:0] htrans,
  // Monitor and multiplexer
  input wire logic       clk_fail_detect,
  input wire logic       switch_done,
  // Control outputs
  input wire logic       osc_switch_request,
  input wire logic       secondary_osc_enable,
  input wire logic       clock_fail_flag,
  input wire logic [2:0] new_osc_select
);
  logic wr_q;
  // Marks the data phase of any bus write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel & hready & htrans[1] & hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!por_n || !hresetn);
  property p_cf_set; clk_fail_detect |=> clock_fail_flag; endproperty
  a_cf_set: assert property (p_cf_set) else $error("fail flag missed");
  property p_cf_hold; clock_fail_flag && !wr_q |=> clock_fail_flag; endproperty
  a_cf_hold: assert property (p_cf_hold) else $error("fail flag lost");
  property p_en_chg; $changed(secondary_osc_enable) |-> $past(wr_q); endproperty
  a_en_chg: assert property (p_en_chg) else $error("enable moved");
  property p_req_rise; $rose(osc_switch_request) |-> $past(wr_q); endproperty
  a_req_rise: assert property (p_req_rise) else $error("request rose");
  property p_req_done; osc_switch_request && switch_done |=> !osc_switch_request; endproperty
  a_req_done: assert property (p_req_done) else $error("request held");
  property p_sel_hold; osc_switch_request |=> $stable(new_osc_select); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
  property p_keep;
    disable iff (!por_n) !hresetn |=> $stable(secondary_osc_enable) && $stable(new_osc_select);
  endproperty
  a_keep: assert property (p_keep) else $error("bus reset hit fields");
  // Main scenarios
  c_fail: cover property (clk_fail_detect);
  c_done: cover property (osc_switch_request && switch_done);
  c_rise: cover property ($rose(osc_switch_request));
endmodule // osw_osc_ctrl_props

// [tb/test_oscillator_switch_control.sv]
// Register-level test of the oscillator switch control block
`timescale 1ns/10ps
module test_oscillator_switch_control import osw_pkg::*;;
  logic        hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, hready;
  logic        clk_fail_detect = 0, switch_done = 0, hreadyout, hresp;
  logic        osc_switch_request, secondary_osc_enable, clock_fail_flag;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, cur_osc_sel = 3'h5, new_osc_select;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  int          num_errors = 0, n_checks = 0;
  // Single slave drives the bus ready
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  osw_osc_ctrl i_dut (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .por_n                (por_n),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hreadyout),
    .hrdata               (hrdata),
    .hresp                (hresp),
    .clk_fail_detect      (clk_fail_detect),
    .switch_done          (switch_done),
    .cur_osc_sel          (cur_osc_sel),
    .new_osc_select       (new_osc_select),
    .osc_switch_request   (osc_switch_request),
    .secondary_osc_enable (secondary_osc_enable),
    .clock_fail_flag      (clock_fail_flag)
  );
  // Compare and count
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
  endtask
  // One single transfer, read data left in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wt();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wt();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic unl;
    bus(1'b1, 8'h04, {16'h0, OSW_KEY1});
    bus(1'b1, 8'h04, {16'h0, OSW_KEY2});
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    rd(8'h00, 32'h5000);
    rd(8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'h0702);
    rd(8'h00, 32'h5000);
    unl();
    bus(1'b1, 8'h00, 32'h0302);
    rd(8'h00, 32'h5302);
    chk({28'h0, new_osc_select, secondary_osc_enable}, 32'h7);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, {16'h0, OSW_KEY1});
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, {16'h0, OSW_KEY2});
    bus(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h5302);
    // Reading the key register shows the opening and does not consume it
    unl();
    rd(8'h04, 32'h2);
    // Selection is frozen while a switch request is pending
    bus(1'b1, 8'h00, 32'h0603);
    rd(8'h00, 32'h5603);
    chk({31'h0, osc_switch_request}, 32'h1);
    unl();
    bus(1'b1, 8'h00, 32'h0102);
    rd(8'h00, 32'h5603);
    chk({29'h0, new_osc_select}, 32'h6);
    switch_done <= 1'b1;
    @(posedge hclk);
    switch_done <= 1'b0;
    clk_fail_detect <= 1'b1;
    @(posedge hclk);
    clk_fail_detect <= 1'b0;
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h560a);
    chk({31'h0, clock_fail_flag}, 32'h1);
    unl();
    bus(1'b1, 8'h00, 32'h0002);
    rd(8'h00, 32'h5002);
    chk({31'h0, clock_fail_flag}, 32'h0);
    // Failure during a clearing write keeps the flag set
    unl();
    clk_fail_detect <= 1'b1;
    bus(1'b1, 8'h00, 32'h0002);
    clk_fail_detect <= 1'b0;
    rd(8'h00, 32'h500a);
    // Power-on reset held two edges so the checker sees it at an edge
    por_n <= 1'b0;
    repeat (2) @(posedge hclk);
    por_n <= 1'b1;
    rd(8'h00, 32'h5000);
    final_report();
  end
endmodule // test_oscillator_switch_control

bind osw_osc_ctrl osw_osc_ctrl_props i_props (
  .hclk                 (hclk),
  .hresetn              (hresetn),
  .por_n                (por_n),
  .hsel                 (hsel),
  .hwrite               (hwrite),
  .hready               (hready),
  .htrans               (htrans),
  .clk_fail_detect      (clk_fail_detect),
  .switch_done          (switch_done),
  .osc_switch_request   (osc_switch_request),
  .secondary_osc_enable (secondary_osc_enable),
  .clock_fail_flag      (clock_fail_flag),
  .new_osc_select       (new_osc_select)
);
